// file: logic/phy_strap_led_pins.sv
// Dual-use strap / status LED pins with an Avalon-MM register slave
//
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module phy_strap_led_pins #(
  parameter int unsigned HOLD_CYCLES = int'(strap_led_pkg::COL_HOLD_CYC)
) (
  // Clock and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 nrst_i,
  // Dual-use pins, then the input-only speed strap
  input  wire logic                 addr1_collision_led_pin_i,
  output logic                      addr1_collision_led_pin_o,
  output logic                      addr1_collision_led_pin_oe_o,
  input  wire logic                 addr2_link_led_pin_i,
  output logic                      addr2_link_led_pin_o,
  output logic                      addr2_link_led_pin_oe_o,
  input  wire logic                 addr3_transmit_led_pin_i,
  output logic                      addr3_transmit_led_pin_o,
  output logic                      addr3_transmit_led_pin_oe_o,
  input  wire logic                 speed_select_pin_i,
  // Status from the PHY core
  input  wire logic                 collision_i,
  input  wire logic                 link_up_i,
  // Strapped configuration
  output strap_led_pkg::strap_t     strap_o,
  output strap_led_pkg::mode_t      host_mode_o,
  output logic                      strap_done_o,
  // Avalon-MM slave
  input  wire logic [3:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest
);
  import strap_led_pkg::*;

  logic [3:0]  sync1_r;
  logic [3:0]  sync2_r;
  phase_t      phase_r;
  phase_t      phase_nxt;
  logic [1:0]  wait_r;
  logic [1:0]  wait_nxt;
  strap_t      strap_r;
  strap_t      strap_nxt;
  logic [2:0]  pin_r;
  logic [2:0]  pin_nxt;
  logic [2:0]  oe_r;
  logic [2:0]  oe_nxt;
  logic        ledoff_r;
  logic        ledoff_nxt;
  logic        srst_r;
  logic        srst_nxt;
  logic        wreq_r;
  logic        wreq_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic        col_act;
  logic        req;
  logic        acc;
  logic [31:0] stat_w;

  // Pin and speed inputs pass two flip-flops before use
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end else begin
      sync1_r <= {addr3_transmit_led_pin_i, addr2_link_led_pin_i,
                  addr1_collision_led_pin_i, speed_select_pin_i};
      sync2_r <= sync1_r;
    end
  end

  // Phase: settle, take the straps once, then drive the LEDs
  always_comb begin
    phase_nxt = phase_r;
    wait_nxt  = wait_r;
    strap_nxt = strap_r;
    case (phase_r)
      ST_SAMPLE: begin
        wait_nxt = wait_r + 2'h1;
        if (wait_r == SETTLE_CYC) begin
          phase_nxt = ST_CAPTURE;
        end
      end
      ST_CAPTURE: begin
        strap_nxt.addr3    = sync2_r[3];
        strap_nxt.addr2    = sync2_r[2];
        strap_nxt.stream   = sync2_r[1];
        strap_nxt.speed100 = sync2_r[0];
        phase_nxt          = ST_RUN;
      end
      ST_RUN: begin
        phase_nxt = ST_RUN;
      end
      default: begin
        phase_nxt = ST_SAMPLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_r <= ST_SAMPLE;
      wait_r  <= 2'h0;
      strap_r <= STRAP_RST;
    end else begin
      phase_r <= phase_nxt;
      wait_r  <= wait_nxt;
      strap_r <= strap_nxt;
    end
  end

  // Collision stretcher; a software reset only clears the hold
  led_stretch #(
    .HOLD     (HOLD_CYCLES)
  ) u_col_stretch (
    .ref_clk_i(ref_clk_i),
    .nrst_i   (nrst_i),
    .hit_i    (collision_i && phase_r == ST_RUN),
    .clr_i    (srst_r),
    .active_o (col_act)
  );

  // LED drive: asserted level is the inverse of the strap
  always_comb begin
    oe_nxt  = 3'h0;
    pin_nxt = 3'h0;
    if (phase_r == ST_RUN) begin
      oe_nxt     = 3'h7;
      pin_nxt[0] = strap_r.stream ^ (col_act && !ledoff_r);
      pin_nxt[1] = strap_r.addr2 ^ (link_up_i && !ledoff_r);
      pin_nxt[2] = strap_r.addr3 ^ (link_up_i && !ledoff_r);
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      oe_r  <= 3'h0;
      pin_r <= 3'h0;
    end else begin
      oe_r  <= oe_nxt;
      pin_r <= pin_nxt;
    end
  end

  // Status word
  always_comb begin
    stat_w                           = 32'h0;
    stat_w[STAT_A2]                  = strap_r.addr2;
    stat_w[STAT_A3]                  = strap_r.addr3;
    stat_w[STAT_MODE+1:STAT_MODE]    = {strap_r.stream, strap_r.speed100};
    stat_w[STAT_DONE]                = (phase_r == ST_RUN);
    stat_w[STAT_LINK]                = link_up_i;
    stat_w[STAT_COL]                 = col_act;
  end

  // Bus slave: one wait state, read data registered at the edge that drops waitrequest, write taken one edge later
  assign req = avs_read || avs_write;
  assign acc = req && !wreq_r;

  always_comb begin
    wreq_nxt   = !(req && wreq_r);
    rdata_nxt  = rdata_r;
    ledoff_nxt = ledoff_r;
    srst_nxt   = 1'b0;
    if (avs_read && wreq_r) begin
      case (avs_address)
        CTRL_OFS: rdata_nxt = {30'h0, ledoff_r, 1'b0};
        STAT_OFS: rdata_nxt = stat_w;
        default:  rdata_nxt = 32'h0;
      endcase
    end
    if (acc && avs_write && avs_address == CTRL_OFS && avs_byteenable[0]) begin
      ledoff_nxt = avs_writedata[CTRL_LOFF];
      srst_nxt   = avs_writedata[CTRL_SRST];
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wreq_r   <= 1'b1;
      rdata_r  <= 32'h0;
      ledoff_r <= CTRL_RST[CTRL_LOFF];
      srst_r   <= CTRL_RST[CTRL_SRST];
    end else begin
      wreq_r   <= wreq_nxt;
      rdata_r  <= rdata_nxt;
      ledoff_r <= ledoff_nxt;
      srst_r   <= srst_nxt;
    end
  end

  // Output wiring, all from flip-flops
  assign addr1_collision_led_pin_o    = pin_r[0];
  assign addr2_link_led_pin_o         = pin_r[1];
  assign addr3_transmit_led_pin_o     = pin_r[2];
  assign addr1_collision_led_pin_oe_o = oe_r[0];
  assign addr2_link_led_pin_oe_o      = oe_r[1];
  assign addr3_transmit_led_pin_oe_o  = oe_r[2];
  assign strap_o                      = strap_r;
  assign host_mode_o = mode_t'({strap_r.stream, strap_r.speed100});
  assign strap_done_o                 = oe_r[0];
  assign avs_readdata                 = rdata_r;
  assign avs_waitrequest              = wreq_r;

  // Checks
  sequence s_run;
    phase_r == ST_RUN;
  endsequence

  sequence s_held;
    col_act [*8];
  endsequence

  property p_no_drive_before_run;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (phase_r != ST_RUN) |=> (oe_r == 3'h0);
  endproperty
  a_no_drive_before_run: assert property (p_no_drive_before_run)
    else $error("pin driven before straps taken");

  property p_mode_capture;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (phase_r == ST_CAPTURE) |=> (strap_r.stream == $past(sync2_r[1]))
      && (strap_r.speed100 == $past(sync2_r[0]));
  endproperty
  a_mode_capture: assert property (p_mode_capture)
    else $error("host mode not taken from straps");

  property p_addr2_capture;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (phase_r == ST_CAPTURE) |=> (strap_r.addr2 == $past(sync2_r[2]));
  endproperty
  a_addr2_capture: assert property (p_addr2_capture)
    else $error("address bit 2 not taken from strap");

  property p_addr3_capture;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (phase_r == ST_CAPTURE) |=> (strap_r.addr3 == $past(sync2_r[3]));
  endproperty
  a_addr3_capture: assert property (p_addr3_capture)
    else $error("address bit 3 not taken from strap");

  property p_strap_stable;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    s_run |=> $stable(strap_r) && (phase_r == ST_RUN);
  endproperty
  a_strap_stable: assert property (p_strap_stable)
    else $error("straps changed after capture");

  property p_srst_keeps_pins;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (srst_r && phase_r == ST_RUN) |=> (oe_r == 3'h7) && $stable(strap_r);
  endproperty
  a_srst_keeps_pins: assert property (p_srst_keeps_pins)
    else $error("software reset disturbed pins");

  property p_col_hold;
    @(posedge ref_clk_i) disable iff (!nrst_i || srst_r || srst_nxt)
    (s_run and collision_i) |=> s_held;
  endproperty
  a_col_hold: assert property (p_col_hold)
    else $error("collision indicator not held");

  property p_col_pin;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (s_run and !ledoff_r) |=>
      (addr1_collision_led_pin_o == (strap_r.stream ^ $past(col_act)));
  endproperty
  a_col_pin: assert property (p_col_pin)
    else $error("collision pin level wrong");

  property p_link_pins;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (s_run and !ledoff_r) |=>
      (addr2_link_led_pin_o == (strap_r.addr2 ^ $past(link_up_i)))
      && (addr3_transmit_led_pin_o == (strap_r.addr3 ^ $past(link_up_i)));
  endproperty
  a_link_pins: assert property (p_link_pins)
    else $error("link pin level wrong");

endmodule : phy_strap_led_pins
`default_nettype wire

// file: logic/strap_led_pkg.sv
// Package: constants and types for the strap and status LED pin block
package strap_led_pkg;

  // Clock rate and collision hold time
  localparam longint unsigned CLK_HZ       = 64'd100_000_000;
  localparam longint unsigned COL_HOLD_MS  = 64'd70;
  localparam longint unsigned COL_HOLD_CYC = COL_HOLD_MS * CLK_HZ / 64'd1000;
  localparam int unsigned     HOLD_W       = 23;

  // Cycles after reset release before the straps are taken
  localparam logic [1:0] SETTLE_CYC = 2'h3;

  // Register byte offsets and reset values
  localparam logic [3:0]  CTRL_OFS   = 4'h0;
  localparam logic [3:0]  STAT_OFS   = 4'h4;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam int unsigned CTRL_SRST  = 0;
  localparam int unsigned CTRL_LOFF  = 1;

  // Status field positions
  localparam int unsigned STAT_A2    = 0;
  localparam int unsigned STAT_A3    = 1;
  localparam int unsigned STAT_MODE  = 2;
  localparam int unsigned STAT_DONE  = 4;
  localparam int unsigned STAT_LINK  = 5;
  localparam int unsigned STAT_COL   = 6;

  // Host interface mode, coded as {stream, speed100}
  typedef enum logic [1:0] {
    MODE_MII10   = 2'b00,
    MODE_MII100  = 2'b01,
    MODE_SER10   = 2'b10,
    MODE_SYM100  = 2'b11
  } mode_t;

  // Pin phase
  typedef enum logic [1:0] {
    ST_SAMPLE  = 2'b00,
    ST_CAPTURE = 2'b01,
    ST_RUN     = 2'b10
  } phase_t;

  // Levels taken from the straps
  typedef struct packed {
    logic addr3;
    logic addr2;
    logic stream;
    logic speed100;
  } strap_t;

  localparam strap_t STRAP_RST = 4'h0;

endpackage : strap_led_pkg

// file: logic/led_stretch.sv
// Retriggerable pulse stretcher for the collision indicator
`timescale 1ns/1ns
`default_nettype none
module led_stretch #(
  parameter int unsigned HOLD = 7000000
) (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic nrst_i,
  // Event in, clear, stretched level out
  input  wire logic hit_i,
  input  wire logic clr_i,
  output logic      active_o
);
  import strap_led_pkg::*;

  localparam logic [HOLD_W-1:0] LAST = HOLD_W'(HOLD - 1);

  logic [HOLD_W-1:0] cnt_r;
  logic [HOLD_W-1:0] cnt_nxt;
  logic              act_r;
  logic              act_nxt;

  // Each hit reloads the count, so a new event restarts the hold
  // A hit beats a clear in the same cycle, so no collision is lost
  always_comb begin
    cnt_nxt = cnt_r;
    act_nxt = act_r;
    if (hit_i) begin
      cnt_nxt = LAST;
      act_nxt = 1'b1;
    end else if (clr_i) begin
      cnt_nxt = '0;
      act_nxt = 1'b0;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - HOLD_W'(1);
    end else begin
      act_nxt = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= '0;
      act_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      act_r <= act_nxt;
    end
  end

  assign active_o = act_r;

  // Checks
  property p_hit_reload;
    @(posedge ref_clk_i) disable iff (!nrst_i)
    hit_i |=> (cnt_r == LAST) && act_r;
  endproperty
  a_hit_reload: assert property (p_hit_reload)
    else $error("hold not restarted by new event");

endmodule : led_stretch
`default_nettype wire

// file: verification/board_pulls.sv
// Board model: strap resistors with series status LEDs
`timescale 1ns/1ns
`default_nettype none
module board_pulls (
  // Strap levels fitted on the board
  input  wire logic [2:0] pull_i,
  // Pin drive from the device
  input  wire logic [2:0] pin_o_i,
  input  wire logic [2:0] pin_oe_i,
  // Resolved pin levels and LED state
  output logic [2:0]      level_o,
  output logic [2:0]      lit_o
);
  // Released pins rest at the resistor level, never float
  assign level_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & pull_i);
  // Series LED conducts when driven away from its pull
  assign lit_o = pin_oe_i & (pin_o_i ^ pull_i);
endmodule : board_pulls
`default_nettype wire

// file: verification/test_phy_strap_led_pins.sv
// Testbench for the strap and status LED pin block
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin \
  error_cnt++; $display("wrong value at %0t: got %0h exp %0h", $time, \
  got, exp); end end
module test_phy_strap_led_pins;
  import strap_led_pkg::*;
  localparam int H = 20;
  logic        ref_clk_i = 1'b0;
  logic        nrst_i    = 1'b0;
  logic        spd       = 1'b0;
  logic        col       = 1'b0;
  logic        link      = 1'b0;
  logic [2:0]  pull      = 3'h0;
  logic [3:0]  adr       = 4'h0;
  logic        rd        = 1'b0;
  logic        wr        = 1'b0;
  logic [31:0] wd        = 32'h0;
  logic [3:0]  be        = 4'hF;
  logic [2:0]  po;
  logic [2:0]  poe;
  logic [2:0]  lvl;
  logic [2:0]  lit;
  strap_t      strap;
  mode_t       mode;
  logic        done;
  logic [31:0] rdat;
  logic        wreq;
  logic [31:0] q;
  int          error_cnt;
  int          check_count;

  // Free-running 100 MHz clock
  always #5 ref_clk_i = ~ref_clk_i;

  phy_strap_led_pins #(.HOLD_CYCLES(H)) phy_strap_led_pins_inst (
    .ref_clk_i                   (ref_clk_i),
    .nrst_i                      (nrst_i),
    .addr1_collision_led_pin_i   (lvl[0]),
    .addr1_collision_led_pin_o   (po[0]),
    .addr1_collision_led_pin_oe_o(poe[0]),
    .addr2_link_led_pin_i        (lvl[1]),
    .addr2_link_led_pin_o        (po[1]),
    .addr2_link_led_pin_oe_o     (poe[1]),
    .addr3_transmit_led_pin_i    (lvl[2]),
    .addr3_transmit_led_pin_o    (po[2]),
    .addr3_transmit_led_pin_oe_o (poe[2]),
    .speed_select_pin_i          (spd),
    .collision_i                 (col),
    .link_up_i                   (link),
    .strap_o                     (strap),
    .host_mode_o                 (mode),
    .strap_done_o                (done),
    .avs_address                 (adr),
    .avs_read                    (rd),
    .avs_write                   (wr),
    .avs_writedata               (wd),
    .avs_byteenable              (be),
    .avs_readdata                (rdat),
    .avs_waitrequest             (wreq)
  );

  board_pulls board_pulls_inst (
    .pull_i  (pull),
    .pin_o_i (po),
    .pin_oe_i(poe),
    .level_o (lvl),
    .lit_o   (lit)
  );

  // One Avalon-MM transfer, held until waitrequest is seen low
  // An idle edge follows, so back-to-back calls never clash
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge ref_clk_i);
    end while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge ref_clk_i);
  endtask : bus

  // Hardware reset with the strap pattern chosen by i, then straps and mode
  task automatic strap_test(input int i);
    logic [2:0] p;
    p = {i[0] ^ i[1], ~i[0], i[1]};
    nrst_i <= 1'b0;
    link <= 1'b0;
    pull <= p;
    spd <= i[0];
    repeat (8) @(posedge ref_clk_i);
    `CHK(poe, 3'h0)
    nrst_i <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
    `CHK(done, 1'b1)
    `CHK(poe, 3'h7)
    `CHK(strap, {p[2], p[1], p[0], i[0]})
    `CHK(mode, {p[0], i[0]})
    bus(1'b0, STAT_OFS, 32'h0);
    `CHK(q[4:0], {1'b1, p[0], i[0], p[2], p[1]})
    spd <= ~i[0];
    repeat (3) @(posedge ref_clk_i);
    `CHK(strap[0], i[0])
    $display("test strap %0d done", i);
  endtask : strap_test

  // Link status on both link pins, asserted then deasserted
  task automatic link_test();
    link <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    `CHK(po[2:1], ~pull[2:1])
    `CHK(lit[2:1], 2'h3)
    `CHK(po[0], pull[0])
    link <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    `CHK(po[2:1], pull[2:1])
    $display("test link done");
  endtask : link_test

  // Collision pulse, retriggered before its hold runs out
  task automatic col_test();
    int n;
    n = 0;
    col <= 1'b1;
    @(posedge ref_clk_i);
    col <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    `CHK(po[0], ~pull[0])
    repeat (7) @(posedge ref_clk_i);
    col <= 1'b1;
    @(posedge ref_clk_i);
    col <= 1'b0;
    while (po[0] === ~pull[0] && n < 100) begin
      @(posedge ref_clk_i);
      n++;
    end
    `CHK(n >= H - 1 && n <= H + 3, 1'b1)
    `CHK(po[0], pull[0])
    $display("test collision done");
  endtask : col_test

  // Soft reset, LED disable and the register map
  task automatic reg_test();
    logic [3:0] s;
    s = strap;
    link <= 1'b1;
    col <= 1'b1;
    @(posedge ref_clk_i);
    col <= 1'b0;
    bus(1'b0, STAT_OFS, 32'h0);
    `CHK(q[6:5], 2'h3)
    bus(1'b1, CTRL_OFS, 32'h1);
    repeat (2) @(posedge ref_clk_i);
    `CHK(poe, 3'h7)
    `CHK(strap, s)
    bus(1'b0, STAT_OFS, 32'h0);
    `CHK(q[6], 1'b0)
    bus(1'b1, CTRL_OFS, 32'h2);
    bus(1'b0, CTRL_OFS, 32'h0);
    `CHK(q, 32'h2)
    repeat (2) @(posedge ref_clk_i);
    `CHK(po[2:1], pull[2:1])
    bus(1'b1, CTRL_OFS, 32'h0);
    bus(1'b1, STAT_OFS, 32'hFFFF_FFFF);
    bus(1'b0, 4'h8, 32'h0);
    `CHK(q, 32'h0)
    be <= 4'hE;
    bus(1'b1, CTRL_OFS, 32'h2);
    be <= 4'hF;
    bus(1'b0, CTRL_OFS, 32'h0);
    `CHK(q, 32'h0)
    $display("test registers done");
  endtask : reg_test

  // Counts, verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  // Main sequence: four strap combinations covering all four host modes, then registers
  initial begin
    repeat (2) @(posedge ref_clk_i);
    for (int i = 0; i < 4; i++) begin
      strap_test(i);
      link_test();
      col_test();
    end
    reg_test();
    conclude();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (5000) @(posedge ref_clk_i);
    error_cnt++;
    conclude();
  end
endmodule : test_phy_strap_led_pins
`default_nettype wire
